//--- itm_bus_model.sv
/*
 Bus controller and memory side of the instruction state timer: offers the
 access condition for each cycle the timer costs. Assumes the bench sets the
 fetch and data conditions before a start and holds them for the whole run.
*/
`timescale 1ns/1ns
module itm_bus_model (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_busy,
    input wire itm_pkg::itm_kind_t i_kind,
    input wire itm_pkg::itm_access_t i_fetch_acc,
    input wire itm_pkg::itm_access_t i_data_acc,
    output itm_pkg::itm_access_t o_access
);
    import itm_pkg::*;

    logic idle_r;

    // Idle pattern flips each cycle between all ones and all zeros, and all zeros reads as a valid on-chip memory condition
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            idle_r <= 1'b0;
        end else begin
            idle_r <= ~idle_r;
        end
    end

    // Condition chosen per cycle from the kind being costed, wait count included
    always_comb begin
        if (!i_busy) begin
            o_access = itm_access_t'({9{idle_r}});
        end else if (i_kind == itm_kind_byte || i_kind == itm_kind_word) begin
            o_access = i_data_acc;
        end else begin
            o_access = i_fetch_acc;
        end
    end
endmodule

//--- itm_cycle_cost.sv
/*
 States that one bus or internal cycle costs, from its kind and the access
 condition. Pure combinational; assumes the access condition is legal.
*/
`timescale 1ns/1ns
`include "itm_regs.svh"
module itm_cycle_cost (
    input wire itm_pkg::itm_kind_t i_kind,
    input wire itm_pkg::itm_access_t i_access,
    output logic [7:0] o_states
);
    import itm_pkg::*;

    logic [7:0] wait_1x;
    logic [7:0] wait_2x;
    logic narrow;

    // Wait terms; four wait bits keep the sum well inside eight bits
    assign wait_1x = {4'h0, i_access.wait_states};
    assign wait_2x = {3'h0, i_access.wait_states, 1'b0};
    assign narrow = (i_kind == itm_kind_byte);

    // Cost table; word and fetch cycles on an 8-bit path are two byte transfers
    always_comb begin
        o_states = `ITM_S_MEM;
        if (i_kind == itm_kind_internal) begin
            o_states = `ITM_S_INTERNAL;
        end else begin
            unique case (i_access.region)
                itm_region_mem: begin
                    o_states = `ITM_S_MEM;
                end
                itm_region_periph: begin
                    if (i_access.bus16) begin
                        o_states = `ITM_S_PER16;
                    end else if (narrow) begin
                        o_states = `ITM_S_PER8_BYTE;
                    end else begin
                        o_states = `ITM_S_PER8_WORD;
                    end
                end
                itm_region_ext: begin
                    if (i_access.bus16) begin
                        o_states = i_access.three_state ? `ITM_S_EXT16_3ST + wait_1x
                                                        : `ITM_S_EXT16_2ST;
                    end else if (narrow) begin
                        o_states = i_access.three_state ? `ITM_S_EXT8_3ST_BYTE + wait_1x
                                                        : `ITM_S_EXT8_2ST_BYTE;
                    end else begin
                        o_states = i_access.three_state ? `ITM_S_EXT8_3ST_WORD + wait_2x
                                                        : `ITM_S_EXT8_2ST_WORD;
                    end
                end
                default: begin
                    o_states = `ITM_S_MEM;
                end
            endcase
        end
    end

endmodule

//--- itm_pkg.sv
/*
 Types of the instruction state timer: instruction forms, cycle kinds,
 access conditions and per-category cycle counts. Assumes nothing else.
*/
package itm_pkg;

    typedef enum logic [4:0] {
        itm_add_b_imm = 5'h00,
        itm_add_b_reg = 5'h01,
        itm_add_w_imm = 5'h02,
        itm_add_w_reg = 5'h03,
        itm_add_l_imm = 5'h04,
        itm_add_l_reg = 5'h05,
        itm_add_small_constant_to_address = 5'h06,
        itm_add_with_extend_carry_imm = 5'h07,
        itm_add_with_extend_carry_reg = 5'h08,
        itm_and_b_imm = 5'h09,
        itm_and_b_reg = 5'h0a,
        itm_and_w_imm = 5'h0b,
        itm_and_w_reg = 5'h0c,
        itm_and_l_imm = 5'h0d,
        itm_and_l_reg = 5'h0e,
        itm_and_into_condition_codes = 5'h0f,
        itm_bit_and_carry_reg = 5'h10,
        itm_bit_and_carry_ind = 5'h11,
        itm_bit_and_carry_abs = 5'h12,
        itm_branch_d8 = 5'h13
    } itm_form_t;

    typedef enum logic [2:0] {
        itm_kind_fetch = 3'h0,
        itm_kind_branch_addr = 3'h1,
        itm_kind_stack = 3'h2,
        itm_kind_byte = 3'h3,
        itm_kind_word = 3'h4,
        itm_kind_internal = 3'h5
    } itm_kind_t;

    typedef enum logic [1:0] {
        itm_region_mem = 2'h0,
        itm_region_periph = 2'h1,
        itm_region_ext = 2'h2
    } itm_region_t;

    typedef struct packed {
        itm_region_t region;
        logic bus16;
        logic three_state;
        logic [3:0] wait_states;
    } itm_access_t;

    typedef struct packed {
        logic [1:0] fetch;
        logic [1:0] branch_addr;
        logic [1:0] stack;
        logic [1:0] byte_data;
        logic [1:0] word_data;
        logic [1:0] internal;
    } itm_counts_t;

    typedef enum logic [1:0] {
        itm_st_idle = 2'h0,
        itm_st_run = 2'h1,
        itm_st_done = 2'h2
    } itm_state_t;

endpackage

//--- itm_regs.svh
/*
 Timing constants for the instruction state timer: state costs per cycle
 and the cycle count codes the form decoder uses. Assumes it is included by bare name.
*/
`ifndef ITM_REGS_SVH
`define ITM_REGS_SVH

// States per cycle
`define ITM_S_MEM 8'h02
`define ITM_S_PER8_WORD 8'h06
`define ITM_S_PER8_BYTE 8'h03
`define ITM_S_PER16 8'h03
`define ITM_S_EXT8_2ST_WORD 8'h04
`define ITM_S_EXT8_2ST_BYTE 8'h02
`define ITM_S_EXT8_3ST_WORD 8'h06
`define ITM_S_EXT8_3ST_BYTE 8'h03
`define ITM_S_EXT16_2ST 8'h02
`define ITM_S_EXT16_3ST 8'h03
`define ITM_S_INTERNAL 8'h01

// Cycle counts
`define ITM_CNT_NONE 2'h0
`define ITM_CNT_ONE 2'h1
`define ITM_CNT_TWO 2'h2
`define ITM_CNT_THREE 2'h3

`endif

//--- itm_state_timer.sv
/*
 Instruction state timer: walks the cycles of one instruction, costs each
 against the access condition offered that cycle and reports the total.
 Assumes the bus controller drives i_access for the cycle on o_cycle_kind.
*/
`timescale 1ns/1ns
`include "itm_regs.svh"
module itm_state_timer (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_start,
    input wire itm_pkg::itm_form_t i_form,
    input wire itm_pkg::itm_access_t i_access,
    output logic o_ready,
    output logic o_busy,
    output logic o_done,
    output logic [15:0] o_states,
    output itm_pkg::itm_kind_t o_cycle_kind
);
    import itm_pkg::*;

    itm_state_t state_r;
    itm_counts_t cnt_r;
    itm_counts_t cnt_nxt;
    itm_counts_t start_cnt;
    itm_kind_t kind_r;
    logic [15:0] acc_r;
    logic [15:0] acc_nxt;
    logic [15:0] states_r;
    logic [7:0] cur_cost;
    logic ready_r;
    logic busy_r;
    logic done_r;
    logic take;

    // Cycle counts per form; unknown codes cost a single fetch
    function automatic itm_counts_t decode_form(input itm_form_t f);
        itm_counts_t c;
        c = '0;
        unique case (f)
            itm_add_b_imm, itm_add_b_reg, itm_add_w_reg, itm_add_l_reg:
                c.fetch = `ITM_CNT_ONE;
            itm_add_w_imm: c.fetch = `ITM_CNT_TWO;
            itm_add_l_imm: c.fetch = `ITM_CNT_THREE;
            itm_and_b_imm, itm_and_b_reg, itm_and_w_reg:
                c.fetch = `ITM_CNT_ONE;
            itm_and_w_imm, itm_and_l_reg: c.fetch = `ITM_CNT_TWO;
            itm_and_l_imm: c.fetch = `ITM_CNT_THREE;
            itm_add_small_constant_to_address, itm_add_with_extend_carry_imm,
            itm_add_with_extend_carry_reg, itm_and_into_condition_codes:
                c.fetch = `ITM_CNT_ONE;
            itm_bit_and_carry_reg: c.fetch = `ITM_CNT_ONE;
            itm_bit_and_carry_ind, itm_bit_and_carry_abs: begin
                c.fetch = `ITM_CNT_TWO;
                c.byte_data = `ITM_CNT_ONE;
            end
            itm_branch_d8: c.fetch = `ITM_CNT_TWO;
            default: c.fetch = `ITM_CNT_ONE;
        endcase
        return c;
    endfunction

    // Next category still owed, fetches first
    function automatic itm_kind_t first_kind(input itm_counts_t c);
        if (c.fetch != `ITM_CNT_NONE) begin
            return itm_kind_fetch;
        end else if (c.branch_addr != `ITM_CNT_NONE) begin
            return itm_kind_branch_addr;
        end else if (c.stack != `ITM_CNT_NONE) begin
            return itm_kind_stack;
        end else if (c.byte_data != `ITM_CNT_NONE) begin
            return itm_kind_byte;
        end else if (c.word_data != `ITM_CNT_NONE) begin
            return itm_kind_word;
        end
        return itm_kind_internal;
    endfunction

    // Cost of the cycle now on the bus, from this cycle's condition
    itm_cycle_cost u_cost (
        .i_kind(kind_r),
        .i_access(i_access),
        .o_states(cur_cost)
    );

    assign take = (state_r == itm_st_idle) && i_start;
    assign start_cnt = decode_form(i_form);
    assign acc_nxt = acc_r + {8'h00, cur_cost};

    // Retire one cycle of the current kind
    always_comb begin
        cnt_nxt = cnt_r;
        unique case (kind_r)
            itm_kind_fetch: cnt_nxt.fetch = cnt_r.fetch - `ITM_CNT_ONE;
            itm_kind_branch_addr: cnt_nxt.branch_addr = cnt_r.branch_addr - `ITM_CNT_ONE;
            itm_kind_stack: cnt_nxt.stack = cnt_r.stack - `ITM_CNT_ONE;
            itm_kind_byte: cnt_nxt.byte_data = cnt_r.byte_data - `ITM_CNT_ONE;
            itm_kind_word: cnt_nxt.word_data = cnt_r.word_data - `ITM_CNT_ONE;
            itm_kind_internal: cnt_nxt.internal = cnt_r.internal - `ITM_CNT_ONE;
            default: cnt_nxt = '0;
        endcase
    end

    // Sequencer; a start while busy is ignored, the caller watches o_ready
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            state_r <= itm_st_idle;
        end else begin
            unique case (state_r)
                itm_st_idle: if (take) begin
                    state_r <= itm_st_run;
                end
                itm_st_run: if (cnt_nxt == '0) begin
                    state_r <= itm_st_done;
                end
                itm_st_done: state_r <= itm_st_idle;
                default: state_r <= itm_st_idle;
            endcase
        end
    end

    // Remaining counts and the kind presented to the bus controller
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            cnt_r <= '0;
            kind_r <= itm_kind_fetch;
        end else if (take) begin
            cnt_r <= start_cnt;
            kind_r <= first_kind(start_cnt);
        end else if (state_r == itm_st_run) begin
            cnt_r <= cnt_nxt;
            kind_r <= first_kind(cnt_nxt);
        end
    end

    // Running sum; total stays on o_states until the next result
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            acc_r <= 16'h0000;
            states_r <= 16'h0000;
        end else if (take) begin
            acc_r <= 16'h0000;
        end else if (state_r == itm_st_run) begin
            acc_r <= acc_nxt;
            if (cnt_nxt == '0) begin
                states_r <= acc_nxt;
            end
        end
    end

    // Handshake flags
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            ready_r <= 1'b1;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            done_r <= (state_r == itm_st_run) && (cnt_nxt == '0);
            if (take) begin
                ready_r <= 1'b0;
                busy_r <= 1'b1;
            end else if ((state_r == itm_st_run) && (cnt_nxt == '0)) begin
                busy_r <= 1'b0;
            end else if (state_r == itm_st_done) begin
                ready_r <= 1'b1;
            end
        end
    end

    assign o_ready = ready_r;
    assign o_busy = busy_r;
    assign o_done = done_r;
    assign o_states = states_r;
    assign o_cycle_kind = kind_r;

    // Checks on counts and costs
    sequence start_of(itm_form_t f);
        ready_r && i_start && (i_form == f);
    endsequence

    sequence ext_cycle(logic b16, logic three, itm_kind_t k);
        busy_r && (i_access.region == itm_region_ext) && (i_access.bus16 == b16)
            && (i_access.three_state == three) && (kind_r == k);
    endsequence

    sum_on_chip_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        start_of(itm_add_w_imm) ##1 (i_access.region == itm_region_mem)[*2]
        |=> o_done && (o_states == 16'h0004))
        else $error("on-chip two-fetch total is not four states");

    fetch_ext16_cost_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        ext_cycle(1'b1, 1'b1, itm_kind_fetch)
        |-> cur_cost == 8'h03 + {4'h0, i_access.wait_states})
        else $error("16-bit 3-state fetch cost wrong");

    byte_ext8_cost_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        ext_cycle(1'b0, 1'b1, itm_kind_byte)
        |-> cur_cost == 8'h03 + {4'h0, i_access.wait_states})
        else $error("8-bit 3-state byte cost wrong");

    word_periph8_cost_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        busy_r && ((kind_r == itm_kind_word) || (kind_r == itm_kind_fetch))
        && (i_access.region == itm_region_periph) && !i_access.bus16 |-> cur_cost == 8'h06)
        else $error("8-bit peripheral word or fetch cost wrong");

    internal_one_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (kind_r == itm_kind_internal) |-> cur_cost == 8'h01)
        else $error("internal cycle not one state");

    fetch_ext8_wait_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        ext_cycle(1'b0, 1'b1, itm_kind_fetch)
        |-> cur_cost == 8'h06 + {3'h0, i_access.wait_states, 1'b0})
        else $error("8-bit 3-state fetch wait term wrong");

    add_long_imm_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        start_of(itm_add_l_imm) |=> o_busy[*3] ##1 (o_done && !o_busy))
        else $error("32-bit immediate add not three fetches");

    and_long_reg_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        start_of(itm_and_l_reg) |=> (o_busy && (o_cycle_kind == itm_kind_fetch))[*2]
        ##1 o_done)
        else $error("32-bit register and not two fetches");

    single_fetch_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        ready_r && i_start && ((i_form == itm_and_into_condition_codes)
            || (i_form == itm_add_with_extend_carry_reg)
            || (i_form == itm_add_with_extend_carry_imm)
            || (i_form == itm_add_small_constant_to_address))
        |=> o_busy ##1 o_done)
        else $error("single-fetch form took more than one cycle");

    bit_and_mem_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        start_of(itm_bit_and_carry_ind) |=> (o_cycle_kind == itm_kind_fetch)[*2]
        ##1 (o_cycle_kind == itm_kind_byte) ##1 o_done)
        else $error("memory bit-and sequence wrong");

    branch_two_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        start_of(itm_branch_d8) |=> (o_busy && (o_cycle_kind == itm_kind_fetch))[*2]
        ##1 o_done)
        else $error("short branch not two fetches");

    cost_per_cycle_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        start_of(itm_add_small_constant_to_address) ##1 1'b1
        |=> o_done && (o_states == {8'h00, $past(cur_cost)}))
        else $error("total ignores this cycle's access condition");

endmodule

//--- tb_instruction_state_timing.sv
/*
 Self-checking bench of the instruction state timer: a table of forms and
 access conditions with their expected totals, then reset and refusal cases.
 Assumes the bus model answers each cycle with the configured condition.
*/
`timescale 1ns/1ns
`define CHK(got, exp) \
    num_checks++; \
    if ((got) !== (exp)) begin \
        fails++; \
        $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp); \
    end
module tb_instruction_state_timing;
    import itm_pkg::*;

    typedef struct packed {
        itm_form_t f;
        itm_access_t fa;
        itm_access_t da;
        logic [15:0] exp;
        logic [2:0] n;
    } itm_tb_row_t;

    localparam itm_access_t acc_mem = '{itm_region_mem, 1'b0, 1'b0, 4'h0};
    localparam itm_access_t acc_p8 = '{itm_region_periph, 1'b0, 1'b0, 4'h0};
    localparam itm_access_t acc_p16 = '{itm_region_periph, 1'b1, 1'b0, 4'h0};
    localparam itm_access_t acc_e8_2 = '{itm_region_ext, 1'b0, 1'b0, 4'h0};
    localparam itm_access_t acc_e8_3w1 = '{itm_region_ext, 1'b0, 1'b1, 4'h1};
    localparam itm_access_t acc_e8_3wf = '{itm_region_ext, 1'b0, 1'b1, 4'hf};
    localparam itm_access_t acc_e16_2 = '{itm_region_ext, 1'b1, 1'b0, 4'h0};
    localparam itm_access_t acc_e16_3w2 = '{itm_region_ext, 1'b1, 1'b1, 4'h2};
    // Spare region code, costed as on-chip memory
    localparam itm_access_t acc_r3 = '{itm_region_t'(2'h3), 1'b1, 1'b1, 4'h7};

    // Form, fetch condition, data condition, total states, cycle count
    localparam itm_tb_row_t rows [25] = '{
        '{itm_add_b_imm, acc_mem, acc_mem, 16'h0002, 3'h1},
        '{itm_add_b_reg, acc_p8, acc_mem, 16'h0006, 3'h1},
        '{itm_add_w_imm, acc_p16, acc_mem, 16'h0006, 3'h2},
        '{itm_add_w_reg, acc_e8_2, acc_mem, 16'h0004, 3'h1},
        '{itm_add_l_imm, acc_e8_3w1, acc_mem, 16'h0018, 3'h3},
        '{itm_add_l_reg, acc_e16_2, acc_mem, 16'h0002, 3'h1},
        '{itm_add_small_constant_to_address, acc_e16_3w2, acc_mem, 16'h0005, 3'h1},
        '{itm_add_with_extend_carry_imm, acc_e8_3wf, acc_mem, 16'h0024, 3'h1},
        '{itm_add_with_extend_carry_reg, acc_mem, acc_mem, 16'h0002, 3'h1},
        '{itm_and_b_imm, acc_p8, acc_mem, 16'h0006, 3'h1},
        '{itm_and_b_reg, acc_p16, acc_mem, 16'h0003, 3'h1},
        '{itm_and_w_imm, acc_e8_2, acc_mem, 16'h0008, 3'h2},
        '{itm_and_w_reg, acc_mem, acc_mem, 16'h0002, 3'h1},
        '{itm_and_l_imm, acc_e16_3w2, acc_mem, 16'h000f, 3'h3},
        '{itm_and_l_reg, acc_e8_3w1, acc_mem, 16'h0010, 3'h2},
        '{itm_and_into_condition_codes, acc_p8, acc_mem, 16'h0006, 3'h1},
        '{itm_bit_and_carry_reg, acc_e8_2, acc_mem, 16'h0004, 3'h1},
        '{itm_bit_and_carry_ind, acc_mem, acc_p8, 16'h0007, 3'h3},
        '{itm_bit_and_carry_abs, acc_e16_2, acc_e8_3w1, 16'h0008, 3'h3},
        '{itm_branch_d8, acc_e8_3wf, acc_mem, 16'h0048, 3'h2},
        '{itm_bit_and_carry_ind, acc_p16, acc_e8_2, 16'h0008, 3'h3},
        '{itm_bit_and_carry_abs, acc_e8_3wf, acc_e16_3w2, 16'h004d, 3'h3},
        '{itm_add_w_imm, acc_mem, acc_mem, 16'h0004, 3'h2},
        '{itm_and_w_imm, acc_r3, acc_mem, 16'h0004, 3'h2},
        '{itm_form_t'(5'h1f), acc_mem, acc_mem, 16'h0002, 3'h1}
    };

    logic i_clk_sys = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_start = 1'b0;
    itm_form_t i_form = itm_add_b_imm;
    itm_access_t i_access;
    itm_access_t fetch_acc = acc_mem;
    itm_access_t data_acc = acc_mem;
    logic o_ready;
    logic o_busy;
    logic o_done;
    logic [15:0] o_states;
    itm_kind_t o_cycle_kind;
    int fails = 0;
    int num_checks = 0;

    itm_state_timer DUT (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_start(i_start),
        .i_form(i_form),
        .i_access(i_access),
        .o_ready(o_ready),
        .o_busy(o_busy),
        .o_done(o_done),
        .o_states(o_states),
        .o_cycle_kind(o_cycle_kind)
    );

    itm_bus_model bus (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_busy(o_busy),
        .i_kind(o_cycle_kind),
        .i_fetch_acc(fetch_acc),
        .i_data_acc(data_acc),
        .o_access(i_access)
    );

    // Free-running system clock, 10 ns period
    initial begin
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    task automatic final_report;
        if (fails == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Times one form; hold keeps a second start up while busy, which must be ignored
    task automatic run_one(input itm_tb_row_t r, input logic hold);
        int k;
        fetch_acc = r.fa;
        data_acc = r.da;
        i_form = r.f;
        `CHK(o_ready, 1'b1)
        i_start = 1'b1;
        @(posedge i_clk_sys);
        #1;
        i_start = hold;
        i_form = itm_branch_d8;
        // First walked cycle is always a fetch
        `CHK(o_busy, 1'b1)
        `CHK(o_ready, 1'b0)
        `CHK(o_cycle_kind, itm_kind_fetch)
        k = 1;
        while (o_done !== 1'b1 && k < 8) begin
            @(posedge i_clk_sys);
            #1;
            k++;
        end
        if (o_done !== 1'b1) begin
            fails++;
            final_report();
        end
        `CHK(k, 32'(r.n) + 1)
        `CHK(o_states, r.exp)
        `CHK(o_busy, 1'b0)
        // A held start in the done cycle must be refused too
        @(posedge i_clk_sys);
        #1;
        `CHK(o_done, 1'b0)
        `CHK(o_ready, 1'b1)
        `CHK(o_busy, 1'b0)
        `CHK(o_states, r.exp)
    endtask

    initial begin
        repeat (12) @(posedge i_clk_sys);
        #1;
        `CHK(o_ready, 1'b1)
        `CHK(o_busy, 1'b0)
        `CHK(o_done, 1'b0)
        `CHK(o_states, 16'h0000)
        `CHK(o_cycle_kind, itm_kind_fetch)
        i_reset_n = 1'b1;
        // Table rows back to back, each start at the first ready cycle
        foreach (rows[i]) begin
            run_one(rows[i], 1'b0);
        end
        // Start held high while busy must not restart or alter the total
        run_one(rows[4], 1'b1);
        run_one(rows[21], 1'b1);
        // Reset in mid-run abandons the instruction and clears the total
        fetch_acc = acc_e8_3wf;
        i_form = itm_add_l_imm;
        i_start = 1'b1;
        @(posedge i_clk_sys);
        #1;
        i_start = 1'b0;
        @(posedge i_clk_sys);
        #1;
        i_reset_n = 1'b0;
        @(posedge i_clk_sys);
        #1;
        `CHK(o_busy, 1'b0)
        `CHK(o_ready, 1'b1)
        `CHK(o_done, 1'b0)
        `CHK(o_states, 16'h0000)
        `CHK(o_cycle_kind, itm_kind_fetch)
        i_reset_n = 1'b1;
        run_one(rows[18], 1'b0);
        final_report();
    end
endmodule
